// ---- pie_pkg.sv ----
// constants shared by the peripheral interrupt enable register block
package pie_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE_A = 8'h00;
    localparam logic [7:0] OFS_ENABLE_B = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_ACTIVE_A = 8'h0c;
    localparam logic [7:0] OFS_ACTIVE_B = 8'h10;
    localparam logic [7:0] OFS_INT_STATUS = 8'h14;
    localparam logic [7:0] OFS_INT_MASK = 8'h18;

    // ------------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------------
    localparam int EN_W = 8;
    localparam int CTRL_W = 2;
    localparam int INT_W = 2;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] ENABLE_A_MASK_FULL = 8'hff;
    localparam logic [7:0] ENABLE_A_MASK_SMALL = 8'h7f;
    localparam logic [7:0] ENABLE_B_MASK = 8'hcf;
    localparam int PARALLEL_BIT = 7;
    localparam int CTRL_GROUP_BIT = 0;
    localparam int CTRL_PRIO_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int STAT_REQ_RISE_BIT = 0;
    localparam int STAT_BUS_ERR_BIT = 1;
    localparam logic [1:0] INT_RESET = 2'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// ---- pie_irq_gate.sv ----
// combines pending flags with enables into the peripheral request
`timescale 1ns/100ps
`default_nettype none
module pie_irq_gate (
    input wire logic [7:0] flagsA,
    input wire logic [7:0] flagsB,
    input wire logic [7:0] enA,
    input wire logic [7:0] enB,
    input wire logic groupEn,
    input wire logic priorityOn,
    output logic req
);
    // flags are only read here, never altered by the enables
    assign req = ((|(flagsA & enA)) | (|(flagsB & enB)))
                 & (groupEn | priorityOn);
endmodule
`default_nettype wire

// ---- pie_enable_regs.sv ----
// peripheral interrupt enable registers with apb slave and gating
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module pie_enable_regs #(
    parameter bit HAS_PARALLEL_PORT = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] flagsA,
    input wire logic [7:0] flagsB,
    output logic [7:0] irqEnableA,
    output logic [7:0] irqEnableB,
    output logic periphIrqReq,
    output logic irq
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [pie_pkg::EN_W-1:0] enA;
        logic [pie_pkg::EN_W-1:0] enB;
        logic [pie_pkg::CTRL_W-1:0] ctrl;
        logic [pie_pkg::INT_W-1:0] intStat;
        logic [pie_pkg::INT_W-1:0] intMask;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic req;
        logic irq;
    } pie_state_t;

    // small package drops the parallel port bit entirely
    localparam logic [7:0] MASK_A = HAS_PARALLEL_PORT ?
        pie_pkg::ENABLE_A_MASK_FULL : pie_pkg::ENABLE_A_MASK_SMALL;

    pie_state_t st;
    pie_state_t next_st;
    logic gateReq;
    logic access;
    logic done;
    logic mapped;
    logic [pie_pkg::INT_W-1:0] intSet;
    logic [pie_pkg::INT_W-1:0] intClr;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic isMapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a == pie_pkg::OFS_ENABLE_A) begin
            hit = 1'b1;
        end else if (a == pie_pkg::OFS_ENABLE_B) begin
            hit = 1'b1;
        end else if (a == pie_pkg::OFS_CONTROL) begin
            hit = 1'b1;
        end else if (a == pie_pkg::OFS_ACTIVE_A) begin
            hit = 1'b1;
        end else if (a == pie_pkg::OFS_ACTIVE_B) begin
            hit = 1'b1;
        end else if (a == pie_pkg::OFS_INT_STATUS) begin
            hit = 1'b1;
        end else if (a == pie_pkg::OFS_INT_MASK) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    function automatic logic [31:0] readMux(input logic [7:0] a,
                                            input pie_state_t s);
        logic [31:0] d;
        d = pie_pkg::RDATA_ZERO;
        if (a == pie_pkg::OFS_ENABLE_A) begin
            d = 32'(s.enA);
        end else if (a == pie_pkg::OFS_ENABLE_B) begin
            d = 32'(s.enB);
        end else if (a == pie_pkg::OFS_CONTROL) begin
            d = 32'(s.ctrl);
        end else if (a == pie_pkg::OFS_ACTIVE_A) begin
            d = 32'(flagsA & s.enA);
        end else if (a == pie_pkg::OFS_ACTIVE_B) begin
            d = 32'(flagsB & s.enB);
        end else if (a == pie_pkg::OFS_INT_STATUS) begin
            d = 32'(s.intStat);
        end else if (a == pie_pkg::OFS_INT_MASK) begin
            d = 32'(s.intMask);
        end
        return d;
    endfunction

    // ------------------------------------------------------------------
    // request gating
    // ------------------------------------------------------------------
    pie_irq_gate u_gate (
        .flagsA(flagsA),
        .flagsB(flagsB),
        .enA(st.enA),
        .enB(st.enB),
        .groupEn(st.ctrl[pie_pkg::CTRL_GROUP_BIT]),
        .priorityOn(st.ctrl[pie_pkg::CTRL_PRIO_BIT]),
        .req(gateReq)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        access = psel & penable;
        // one wait state so read data can come from a flop
        done = access & st.pready;
        mapped = isMapped(paddr);
        intSet = '0;
        intClr = '0;
        next_st.pready = access & ~st.pready;
        if (access && !st.pready) begin
            next_st.prdata = readMux(paddr, st);
            next_st.pslverr = ~mapped;
        end else if (!access) begin
            next_st.prdata = pie_pkg::RDATA_ZERO;
            next_st.pslverr = 1'b0;
        end
        if (done && pwrite) begin
            if (paddr == pie_pkg::OFS_ENABLE_A) begin
                next_st.enA = pwdata[7:0] & MASK_A;
            end else if (paddr == pie_pkg::OFS_ENABLE_B) begin
                next_st.enB = pwdata[7:0] & pie_pkg::ENABLE_B_MASK;
            end else if (paddr == pie_pkg::OFS_CONTROL) begin
                next_st.ctrl = pwdata[pie_pkg::CTRL_W-1:0];
            end else if (paddr == pie_pkg::OFS_INT_STATUS) begin
                intClr = pwdata[pie_pkg::INT_W-1:0];
            end else if (paddr == pie_pkg::OFS_INT_MASK) begin
                next_st.intMask = pwdata[pie_pkg::INT_W-1:0];
            end
        end
        intSet[pie_pkg::STAT_REQ_RISE_BIT] = gateReq & ~st.req;
        intSet[pie_pkg::STAT_BUS_ERR_BIT] = done & ~mapped;
        // a new event beats a clear in the same cycle
        next_st.intStat = (st.intStat & ~intClr) | intSet;
        next_st.req = gateReq;
        next_st.irq = |(next_st.intStat & next_st.intMask);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st.enA <= pie_pkg::ENABLE_RESET;
            st.enB <= pie_pkg::ENABLE_RESET;
            st.ctrl <= pie_pkg::CTRL_RESET;
            st.intStat <= pie_pkg::INT_RESET;
            st.intMask <= pie_pkg::INT_RESET;
            st.pready <= 1'b0;
            st.prdata <= pie_pkg::RDATA_ZERO;
            st.pslverr <= 1'b0;
            st.req <= 1'b0;
            st.irq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign irqEnableA = st.enA;
    assign irqEnableB = st.enB;
    assign periphIrqReq = st.req;
    assign irq = st.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_reset_clear: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> (st.enA == 8'h00 && st.enB == 8'h00))
        else $error("enables not cleared by reset");
    chk_unimpl_zero: assert property (@(posedge clk) disable iff (rst)
        (st.enB & ~pie_pkg::ENABLE_B_MASK) == 8'h00)
        else $error("unimplemented enable bit stored");
    chk_parallel_absent: assert property (@(posedge clk) disable iff (rst)
        !HAS_PARALLEL_PORT |-> !st.enA[pie_pkg::PARALLEL_BIT])
        else $error("absent parallel enable bit set");
    chk_write_a: assert property (@(posedge clk) disable iff (rst)
        (done && pwrite && paddr == pie_pkg::OFS_ENABLE_A)
        |=> st.enA == ($past(pwdata[7:0]) & MASK_A))
        else $error("enable a write lost");
    chk_write_b: assert property (@(posedge clk) disable iff (rst)
        (done && pwrite && paddr == pie_pkg::OFS_ENABLE_B)
        |=> st.enB == ($past(pwdata[7:0]) & pie_pkg::ENABLE_B_MASK))
        else $error("enable b write lost");
    chk_read_a: assert property (@(posedge clk) disable iff (rst)
        (access && !st.pready && paddr == pie_pkg::OFS_ENABLE_A)
        |=> (pready && prdata == 32'($past(st.enA))))
        else $error("enable a readback wrong");
    chk_group_block: assert property (@(posedge clk) disable iff (rst)
        (st.ctrl == 2'h0) |=> !periphIrqReq)
        else $error("request passed without group enable");
    chk_source_gate: assert property (@(posedge clk) disable iff (rst)
        periphIrqReq == $past(((|(flagsA & st.enA)) | (|(flagsB & st.enB)))
            & (st.ctrl[pie_pkg::CTRL_GROUP_BIT]
            | st.ctrl[pie_pkg::CTRL_PRIO_BIT])))
        else $error("peripheral request not flag and enable");
    chk_pready_wait: assert property (@(posedge clk) disable iff (rst)
        (access && !st.pready) |=> pready ##1 !pready)
        else $error("apb wait state wrong");
    chk_irq_level: assert property (@(posedge clk) disable iff (rst)
        irq == |(st.intStat & st.intMask))
        else $error("interrupt output mismatch");
endmodule
`default_nettype wire

// ---- pie_flag_source.sv ----
// model of on-chip peripherals that raise sticky pending flags
`timescale 1ns/100ps
`default_nettype none
module pie_flag_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] setA,
    input wire logic [7:0] setB,
    input wire logic [7:0] clrA,
    input wire logic [7:0] clrB,
    output logic [7:0] flagsA,
    output logic [7:0] flagsB
);
    // a flag stays up until software clears it, so a late enable still sees it
    always_ff @(posedge clk) begin
        if (rst) begin
            flagsA <= 8'h00;
            flagsB <= 8'h00;
        end else begin
            flagsA <= (flagsA & ~clrA) | setA;
            flagsB <= (flagsB & ~clrB) | setB;
        end
    end
endmodule
`default_nettype wire

// ---- test_peripheral_irq_enable_regs.sv ----
// self-checking bench for the peripheral interrupt enable registers
`timescale 1ns/100ps
`default_nettype none
module test_peripheral_irq_enable_regs;
    localparam logic [7:0] EA = pie_pkg::OFS_ENABLE_A;
    localparam logic [7:0] EB = pie_pkg::OFS_ENABLE_B;
    localparam logic [7:0] CT = pie_pkg::OFS_CONTROL;
    localparam logic [7:0] ST = pie_pkg::OFS_INT_STATUS;
    localparam logic [7:0] MK = pie_pkg::OFS_INT_MASK;
    logic clk, rst, psel, penable, pwrite, pslverr, pready, periphIrqReq;
    logic irq, rdErr;
    logic [7:0] paddr, setA, setB, clrA, clrB, flagsA, flagsB;
    logic [7:0] irqEnableA, irqEnableB, smallEnA;
    logic [31:0] pwdata, prdata, rd;
    int errors = 0;
    int tests_run = 0;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    pie_flag_source FS (.clk(clk), .rst(rst), .setA(setA), .setB(setB),
        .clrA(clrA), .clrB(clrB), .flagsA(flagsA), .flagsB(flagsB));
    pie_enable_regs #(.HAS_PARALLEL_PORT(1'b1)) DUT (.clk(clk), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flagsA(flagsA), .flagsB(flagsB),
        .irqEnableA(irqEnableA), .irqEnableB(irqEnableB),
        .periphIrqReq(periphIrqReq), .irq(irq));
    // small variant shares the bus; only its enable output is watched
    pie_enable_regs #(.HAS_PARALLEL_PORT(1'b0)) DUT2 (.clk(clk), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .flagsA(flagsA),
        .flagsB(flagsB), .irqEnableA(smallEnA), .irqEnableB(),
        .periphIrqReq(), .irq());
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one idle cycle before each setup keeps every signal to one change
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready is taken on the rising edge, as the slave sees it
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            tally_and_finish();
        end
        rd = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {setA, setB, clrA, clrB} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        apb(0, EA, 0); check("enable a", 32'h0000_0000, rd);
        apb(0, EB, 0); check("enable b", 32'h0000_0000, rd);
        apb(1, EA, 32'hffff_ffff); apb(0, EA, 0);
        check("enable a rw", 32'h0000_00ff, rd);
        check("enable a port", 32'h0000_00ff, irqEnableA);
        check("small enable a", 32'h0000_007f, smallEnA);
        apb(1, EB, 32'hffff_ffff); apb(0, EB, 0);
        check("enable b rw", 32'h0000_00cf, rd);
        check("enable b port", 32'h0000_00cf, irqEnableB);
        $display("test access done");
        apb(1, CT, 32'h0000_0001);
        apb(0, CT, 0); check("control", 32'h0000_0001, rd);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            setA <= (i < 8) ? 8'(1 << i) : 8'h00;
            setB <= (i < 8) ? 8'h00 : 8'(1 << (i - 8));
            @(posedge clk);
            {setA, setB} <= '0;
            settle();
            check("request", (i < 8) ? 1 : pie_pkg::ENABLE_B_MASK[i - 8],
                  periphIrqReq);
            @(posedge clk);
            {clrA, clrB} <= 16'hffff;
            @(posedge clk);
            {clrA, clrB} <= '0;
        end
        setA <= 8'h01;
        @(posedge clk);
        setA <= 8'h00;
        apb(1, CT, 0); settle(); check("group off", 0, periphIrqReq);
        apb(1, CT, 2); settle(); check("prio on", 1, periphIrqReq);
        apb(1, CT, 1); apb(1, EA, 32'h0000_00fe); settle();
        check("blocked", 0, periphIrqReq);
        check("flag kept", 32'h0000_0001, flagsA);
        $display("test gating done");
        apb(1, ST, 32'h0000_0003); apb(1, MK, 32'h0000_0001);
        apb(1, EA, 32'h0000_0001); settle();
        check("irq raised", 1, irq);
        apb(0, pie_pkg::OFS_ACTIVE_A, 0);
        check("active a", 32'h0000_0001, rd);
        @(posedge clk);
        setB <= 8'h80;
        @(posedge clk);
        setB <= 8'h00;
        apb(0, pie_pkg::OFS_ACTIVE_B, 0);
        check("active b", 32'h0000_0080, rd);
        apb(1, ST, 32'h0000_0001); settle(); check("irq cleared", 0, irq);
        apb(0, 8'h1c, 0); check("unmapped err", 1, rdErr);
        check("unmapped data", 32'h0000_0000, rd);
        apb(0, ST, 0); check("status", 32'h0000_0002, rd);
        apb(1, MK, 32'h0000_0002); settle(); check("irq mask", 1, irq);
        apb(1, MK, 32'h0000_0000); settle(); check("irq masked", 0, irq);
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
